//--- hw/gpio2_pin_control.v
// Control, function routing and edge interrupt for one general-purpose pin.
// Assumes pad input and function sources are synchronous to clk_sys_in;
// the pad driver, pulls and supply switch sit outside and obey the outputs.
//
// Contract
// - Direction bit: 0 output, 1 input
// - Pull field: none, down, up; reset down
// - Interrupt mode 1: both edges
// - Single edge: polarity picks rising or falling
// - Polarity bit: 1 non-inverted, reset 1
// - Output type: push-pull or open-drain
// - Enable bit 0 tri-states pin, reset 0
// - Supply domain select bit 11
// - Input codes 2-7 to request functions
// - Input codes 8-15 to scaling/hardware inputs
// - Output code 0 software, 1 oscillator
// - Output codes 2-4 state indications
// - Output codes 10-13 enables and power good
// - Output code 14 clock, 15 reset
// - Control register reset value 16'hA400
`include "pin2_control_regs.vh"
`default_nettype none

module gpio2_pin_control #(
    parameter [15:0] LONG_DEBOUNCE_CYCLES = `LONG_DEBOUNCE_DEFAULT
) (
    input wire clk_sys_in,
    input wire rst_b_in,
    // AXI4-Lite slave
    input wire [`ADDR_W-1:0] s_axi_awaddr_in,
    input wire s_axi_awvalid_in,
    output wire s_axi_awready_out,
    input wire [31:0] s_axi_wdata_in,
    input wire [3:0] s_axi_wstrb_in,
    input wire s_axi_wvalid_in,
    output wire s_axi_wready_out,
    output reg [1:0] s_axi_bresp_out,
    output reg s_axi_bvalid_out,
    input wire s_axi_bready_in,
    input wire [`ADDR_W-1:0] s_axi_araddr_in,
    input wire s_axi_arvalid_in,
    output wire s_axi_arready_out,
    output reg [31:0] s_axi_rdata_out,
    output reg [1:0] s_axi_rresp_out,
    output reg s_axi_rvalid_out,
    input wire s_axi_rready_in,
    // Pad
    input wire pad_in,
    output reg pad_out,
    output reg pad_oe_b_out,
    output reg pull_up_out,
    output reg pull_down_out,
    output reg supply_domain_out,
    // Output function sources
    input wire osc_32k_in,
    input wire on_state_in,
    input wire sleep_state_in,
    input wire power_change_in,
    input wire dvs_done1_in,
    input wire dvs_done2_in,
    input wire ext_power_en1_in,
    input wire ext_power_en2_in,
    input wire system_supply_good_in,
    input wire converter_power_good_in,
    input wire ext_power_clk_in,
    input wire aux_reset_in,
    // Input function requests, one bit per function code
    output reg [15:0] in_function_out,
    output wire irq_out
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_CTL = 3'h1;
    localparam [2:0] SEL_STAT = 3'h2;
    localparam [2:0] SEL_ENA = 3'h3;
    localparam [2:0] SEL_CLR = 3'h4;
    localparam [2:0] SEL_LVL = 3'h5;

    function [2:0] reg_select;
        input [`ADDR_W-1:0] addr;
        reg [15:0] idx;
        begin
            idx = addr[`ADDR_W-1:2];
            case (idx)
                `IDX_PIN2_CONTROL: reg_select = SEL_CTL;
                `IDX_IRQ_STATUS: reg_select = SEL_STAT;
                `IDX_IRQ_ENABLE: reg_select = SEL_ENA;
                `IDX_IRQ_CLEAR: reg_select = SEL_CLR;
                `IDX_PIN_LEVEL: reg_select = SEL_LVL;
                default: reg_select = SEL_NONE;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg [15:0] pin2_control;
    reg irq_status;
    reg irq_enable;
    reg sw_level;

    wire pin_direction_select = pin2_control[`DIR_BIT];
    wire [1:0] pull_resistor_select = pin2_control[`PULL_HI:`PULL_LO];
    wire edge_interrupt_mode = pin2_control[`INT_MODE_BIT];
    wire io_supply_domain_select = pin2_control[`DOMAIN_BIT];
    wire pin_polarity_select = pin2_control[`POL_BIT];
    wire open_drain_select = pin2_control[`OD_BIT];
    wire pin_drive_enable = pin2_control[`ENA_BIT];
    wire [3:0] pin_function_select = pin2_control[`FN_HI:`FN_LO];

    // ----------------------------------------
    // AXI write channel
    // ----------------------------------------
    reg aw_held;
    reg w_held;
    reg [`ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;

    wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
    wire w_take = s_axi_wvalid_in && s_axi_wready_out;
    wire aw_have = aw_held || aw_take;
    wire w_have = w_held || w_take;
    wire wr_fire = aw_have && w_have && !s_axi_bvalid_out;

    wire [`ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr_in;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata_in;
    wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb_in;
    wire [2:0] wr_sel = reg_select(wr_addr);

    wire [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire [15:0] ctl_mask = lane_mask & `CTL_WMASK;
    wire wr_ctl = wr_fire && (wr_sel == SEL_CTL);
    wire wr_ena = wr_fire && (wr_sel == SEL_ENA) && wr_strb[0];
    wire wr_clr = wr_fire && (wr_sel == SEL_CLR) && wr_strb[0];
    wire wr_lvl = wr_fire && (wr_sel == SEL_LVL) && wr_strb[0];

    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {`ADDR_W{1'b0}};
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr_in;
            end
            if (w_take) begin
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                // Unmapped and read-only status targets both answer SLVERR
                s_axi_bresp_out <= (wr_sel == SEL_NONE || wr_sel == SEL_STAT) ?
                    `RESP_SLVERR : `RESP_OKAY;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                end
                if (w_take) begin
                    w_held <= 1'b1;
                end
                if (s_axi_bvalid_out && s_axi_bready_in) begin
                    s_axi_bvalid_out <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pin2_control <= `CTL_RESET;
            irq_enable <= 1'b0;
            sw_level <= 1'b0;
        end else begin
            if (wr_ctl) begin
                // Undefined bits never take a write
                pin2_control <= (pin2_control & ~ctl_mask) | (wr_data[15:0] & ctl_mask);
            end
            if (wr_ena) begin
                irq_enable <= wr_data[0];
            end
            if (wr_lvl) begin
                sw_level <= wr_data[0];
            end
        end
    end

    // ----------------------------------------
    // AXI read channel
    // ----------------------------------------
    assign s_axi_arready_out = !s_axi_rvalid_out;

    wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
    wire [2:0] rd_sel = reg_select(s_axi_araddr_in);

    reg deb_level;
    reg [31:0] rd_word;
    reg rd_err;

    always @* begin
        rd_word = 32'h0;
        rd_err = 1'b0;
        case (rd_sel)
            SEL_CTL: rd_word = {16'h0, pin2_control};
            SEL_STAT: rd_word = {31'h0, irq_status};
            SEL_ENA: rd_word = {31'h0, irq_enable};
            SEL_LVL: rd_word = {30'h0, deb_level, sw_level};
            SEL_CLR: rd_word = 32'h0;
            default: rd_err = 1'b1;
        endcase
    end

    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= rd_word;
            s_axi_rresp_out <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // Input de-bounce
    // ----------------------------------------
    // Long filter only for the codes that ask for it; a pin level change
    // shorter than the limit is dropped, trading latency for noise immunity
    wire long_filter = (pin_function_select == `FN_IN_GPIO_LONG) ||
        (pin_function_select == `FN_IN_SLEEP_WAKE_LONG) ||
        (pin_function_select == `FN_IN_HWCTL1_LONG) ||
        (pin_function_select == `FN_IN_HWCTL2_LONG);
    wire [15:0] deb_limit = long_filter ? LONG_DEBOUNCE_CYCLES : `SHORT_DEBOUNCE_CYCLES;

    reg [15:0] deb_count;
    reg deb_prev;

    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            deb_level <= 1'b0;
            deb_prev <= 1'b0;
            deb_count <= 16'h0;
        end else begin
            deb_prev <= deb_level;
            if (pad_in == deb_level) begin
                deb_count <= 16'h0;
            end else if (deb_count + 16'h1 >= deb_limit) begin
                deb_level <= pad_in;
                deb_count <= 16'h0;
            end else begin
                deb_count <= deb_count + 16'h1;
            end
        end
    end

    // ----------------------------------------
    // Edge interrupt
    // ----------------------------------------
    wire rise = deb_level && !deb_prev;
    wire fall = !deb_level && deb_prev;
    wire edge_event = pin_direction_select && pin_drive_enable &&
        (edge_interrupt_mode ? (rise || fall) :
        (pin_polarity_select ? rise : fall));
    wire clr_hit = wr_clr && wr_data[0];

    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            irq_status <= 1'b0;
        end else begin
            // A new edge in the clearing cycle survives the clear
            irq_status <= (irq_status && !clr_hit) || edge_event;
        end
    end

    assign irq_out = irq_status && irq_enable;

    // ----------------------------------------
    // Input function routing
    // ----------------------------------------
    wire active_in = pin_polarity_select ? deb_level : !deb_level;
    wire in_mode = pin_direction_select && pin_drive_enable;

    wire [15:0] in_hit;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : in_route
            // Codes 2-7 requests, 8-15 scaling and hardware inputs
            assign in_hit[g] = in_mode && active_in &&
                ({28'h0, pin_function_select} == g);
        end
    endgenerate

    // One register for the whole vector keeps a single driver per output
    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            in_function_out <= 16'h0;
        end else begin
            in_function_out <= in_hit;
        end
    end

    // ----------------------------------------
    // Output function routing
    // ----------------------------------------
    reg out_src;

    always @* begin
        case (pin_function_select)
            `FN_OUT_SW: out_src = sw_level;
            `FN_OUT_OSC: out_src = osc_32k_in;
            `FN_OUT_ON: out_src = on_state_in;
            `FN_OUT_SLEEP: out_src = sleep_state_in;
            `FN_OUT_PWR_CHANGE: out_src = power_change_in;
            `FN_OUT_DVS1: out_src = dvs_done1_in;
            `FN_OUT_DVS2: out_src = dvs_done2_in;
            `FN_OUT_EXT_EN1: out_src = ext_power_en1_in;
            `FN_OUT_EXT_EN2: out_src = ext_power_en2_in;
            `FN_OUT_SYS_GOOD: out_src = system_supply_good_in;
            `FN_OUT_CONVERTER_POWER_GOOD: out_src = converter_power_good_in;
            `FN_OUT_EXT_CLK: out_src = ext_power_clk_in;
            `FN_OUT_AUX_RST: out_src = aux_reset_in;
            default: out_src = 1'b0;
        endcase
    end

    wire out_level = pin_polarity_select ? out_src : !out_src;
    wire driving = !pin_direction_select && pin_drive_enable;

    // ----------------------------------------
    // Pad control
    // ----------------------------------------
    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pad_out <= 1'b0;
            pad_oe_b_out <= 1'b1;
            pull_up_out <= 1'b0;
            pull_down_out <= 1'b0;
            supply_domain_out <= 1'b0;
        end else begin
            if (!driving) begin
                pad_out <= 1'b0;
                pad_oe_b_out <= 1'b1;
            end else if (open_drain_select) begin
                // Only ever pull low; a high level releases the pin
                pad_out <= 1'b0;
                pad_oe_b_out <= out_level;
            end else begin
                pad_out <= out_level;
                pad_oe_b_out <= 1'b0;
            end
            // Reserved pull code leaves both resistors off
            pull_up_out <= (pull_resistor_select == `PULL_UP);
            pull_down_out <= (pull_resistor_select == `PULL_DOWN);
            supply_domain_out <= io_supply_domain_select;
        end
    end

endmodule

`default_nettype wire

//--- hw/pin2_control_regs.vh
// Register map and constants for the second general-purpose pin block.
// Assumes word-indexed register offsets, byte address four times the index.
`ifndef PIN2_CONTROL_REGS_VH
`define PIN2_CONTROL_REGS_VH

// ----------------------------------------
// Register indices and bus widths
// ----------------------------------------
`define ADDR_W 18
`define IDX_PIN2_CONTROL 16'h4039
`define IDX_IRQ_STATUS 16'h4040
`define IDX_IRQ_ENABLE 16'h4041
`define IDX_IRQ_CLEAR 16'h4042
`define IDX_PIN_LEVEL 16'h4043

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_RESET 16'hA400
`define CTL_WMASK 16'hFE8F
`define DIR_BIT 15
`define PULL_HI 14
`define PULL_LO 13
`define INT_MODE_BIT 12
`define DOMAIN_BIT 11
`define POL_BIT 10
`define OD_BIT 9
`define ENA_BIT 7
`define FN_HI 3
`define FN_LO 0

`define PULL_NONE 2'h0
`define PULL_DOWN 2'h1
`define PULL_UP 2'h2

// ----------------------------------------
// Input function codes with long de-bounce
// ----------------------------------------
`define FN_IN_GPIO_LONG 4'h0
`define FN_IN_SLEEP_WAKE_LONG 4'h4
`define FN_IN_HWCTL1_LONG 4'hE
`define FN_IN_HWCTL2_LONG 4'hF

// ----------------------------------------
// Output function codes
// ----------------------------------------
`define FN_OUT_SW 4'h0
`define FN_OUT_OSC 4'h1
`define FN_OUT_ON 4'h2
`define FN_OUT_SLEEP 4'h3
`define FN_OUT_PWR_CHANGE 4'h4
`define FN_OUT_DVS1 4'h8
`define FN_OUT_DVS2 4'h9
`define FN_OUT_EXT_EN1 4'hA
`define FN_OUT_EXT_EN2 4'hB
`define FN_OUT_SYS_GOOD 4'hC
`define FN_OUT_CONVERTER_POWER_GOOD 4'hD
`define FN_OUT_EXT_CLK 4'hE
`define FN_OUT_AUX_RST 4'hF

// ----------------------------------------
// Timing and AXI responses
// ----------------------------------------
`define SHORT_DEBOUNCE_CYCLES 16'h0004
`define LONG_DEBOUNCE_DEFAULT 16'h0400
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- dv/gpio2_pin_control_chk.sv
// Port checker for the pin control block, bound onto its top module.
// Assumes one clock domain and the synchronous active-low reset.
`default_nettype none
module gpio2_pin_control_chk (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic s_axi_rvalid_out,
    input wire logic pad_out,
    input wire logic pad_oe_b_out,
    input wire logic pull_up_out,
    input wire logic pull_down_out,
    input wire logic supply_domain_out,
    input wire logic [15:0] in_function_out,
    input wire logic irq_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    property p_pull_excl; !(pull_up_out && pull_down_out); endproperty
    a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
    property p_od_drive; pad_out |-> !pad_oe_b_out; endproperty
    a_od_drive: assert property (p_od_drive) else $error("high level not driven");
    property p_fn_onehot; $onehot0(in_function_out); endproperty
    a_fn_onehot: assert property (p_fn_onehot) else $error("two input functions");
    property p_in_no_drive; |in_function_out |-> pad_oe_b_out; endproperty
    a_in_no_drive: assert property (p_in_no_drive) else $error("input pin driven");
    property p_rst_tri; $rose(rst_b_in) |-> pad_oe_b_out [*2]; endproperty
    a_rst_tri: assert property (p_rst_tri) else $error("pin driven after reset");
    property p_rst_cfg;
        $rose(rst_b_in) |=> pull_down_out && !pull_up_out && !supply_domain_out && !irq_out;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("bad state after reset");
    property p_wr_ans;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
            |=> s_axi_bvalid_out;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
    property p_rd_ans; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_b_busy; s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out; endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while answering");
endmodule
bind gpio2_pin_control gpio2_pin_control_chk gpio2_pin_control_chk_inst (.*);
`default_nettype wire

//--- dv/pin_partner.sv
// Circuit outside the pin: drives it when asked, otherwise pulls or floats.
// Assumes the block's pad enable is active low.
`default_nettype none
module pin_partner (
    input wire logic clk_in,
    input wire logic pad_drv_in,
    input wire logic pad_oe_b_in,
    input wire logic pull_up_in,
    input wire logic pull_down_in,
    input wire logic ext_en_in,
    input wire logic ext_val_in,
    output var logic level_out
);
    logic flt = 1'b0;
    // A floating pin must not read as a steady level
    always @(posedge clk_in) flt <= ~flt;
    always_comb begin
        if (!pad_oe_b_in) level_out = pad_drv_in;
        else if (ext_en_in) level_out = ext_val_in;
        else if (pull_up_in) level_out = 1'b1;
        else if (pull_down_in) level_out = 1'b0;
        else level_out = flt;
    end
endmodule
`default_nettype wire

//--- dv/gpio2_pin_control_tb_top.sv
// Self-checking bench for the pin control block.
// Assumes the register header and a short long-de-bounce parameter.
`include "pin2_control_regs.vh"
`default_nettype none
module gpio2_pin_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic s_axi_arvalid_in, s_axi_rready_in, pad_in, ext_en, ext_val;
    logic [`ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, pad_out, pad_oe_b_out, pull_up_out, pull_down_out;
    logic supply_domain_out, irq_out;
    logic [15:0] in_function_out;
    logic [11:0] src;
    logic osc_32k_in, on_state_in, sleep_state_in, power_change_in, dvs_done1_in;
    logic dvs_done2_in, ext_power_en1_in, ext_power_en2_in, system_supply_good_in;
    logic converter_power_good_in, ext_power_clk_in, aux_reset_in;
    int error_cnt = 0;
    int checked = 0;
    assign {aux_reset_in, ext_power_clk_in, converter_power_good_in, system_supply_good_in,
        ext_power_en2_in, ext_power_en1_in, dvs_done2_in, dvs_done1_in, power_change_in,
        sleep_state_in, on_state_in, osc_32k_in} = src;
    gpio2_pin_control #(.LONG_DEBOUNCE_CYCLES(16'h0008)) gpio2_pin_control_inst (.*);
    pin_partner pin_partner_inst (.clk_in(clk_sys_in), .pad_drv_in(pad_out),
        .pad_oe_b_in(pad_oe_b_out), .pull_up_in(pull_up_out), .pull_down_in(pull_down_out),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_in));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // Ready is read before the edge's own updates land, so it is the sampled value
    task automatic wr(input logic [15:0] i, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr_in <= {i, 2'b00};
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        r = s_axi_bresp_out;
    endtask
    task automatic rd(input logic [15:0] i, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr_in <= {i, 2'b00};
        s_axi_arvalid_in <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            n++;
            if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        d = s_axi_rdata_out;
        r = s_axi_rresp_out;
    endtask
    function automatic logic exp_src(input logic [3:0] f, input logic [11:0] s,
        input logic sw);
        if (f == 4'h0) return sw;
        if (f < 4'h5) return s[f - 4'h1];
        if (f < 4'h8) return 1'b0;
        return s[f - 4'h4];
    endfunction
    task final_report;
        if (error_cnt == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        error_cnt++;
        final_report;
    end
    initial begin
        int k;
        logic [31:0] d, e;
        logic [1:0] r;
        logic pol, od, sw, lvl;
        {rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_arvalid_in, ext_en, ext_val} = 0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, src} = 0;
        {s_axi_bready_in, s_axi_rready_in, s_axi_wstrb_in} = 6'h3F;
        void'($urandom(32'h495A2DDE));
        repeat (12) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(`IDX_PIN2_CONTROL, d, r);
        chk("ctl_reset", d, 32'h0000A400);
        chk("oe_b_reset", pad_oe_b_out, 32'h1);
        chk("pull_dn_reset", pull_down_out, 32'h1);
        repeat (4) begin
            e = $urandom;
            wr(`IDX_PIN2_CONTROL, e, r);
            rd(`IDX_PIN2_CONTROL, d, r);
            chk("ctl_readback", d, e & 32'h0000FE8F);
        end
        wr(16'h4050, $urandom, r);
        chk("unmapped_wr", r, `RESP_SLVERR);
        rd(16'h4050, d, r);
        chk("unmapped_rd", {d[29:0], r}, `RESP_SLVERR);
        wr(`IDX_IRQ_STATUS, 32'h1, r);
        chk("status_wr", r, `RESP_SLVERR);
        for (k = 0; k < 4; k++) begin
            wr(`IDX_PIN2_CONTROL, (k << 13) | ((k & 1) << 11), r);
            cyc(3);
            chk("pull_up", pull_up_out, k == 2);
            chk("pull_dn", pull_down_out, k == 1);
            chk("supply", supply_domain_out, k & 1);
        end
        for (k = 0; k < 16; k++) begin
            {pol, od, sw} = $urandom;
            src <= $urandom;
            wr(`IDX_PIN_LEVEL, sw, r);
            wr(`IDX_PIN2_CONTROL, (od << 9) | (pol << 10) | 32'h80 | k, r);
            cyc(3);
            lvl = exp_src(k[3:0], src, sw) ^ !pol;
            chk("out_oe_b", pad_oe_b_out, od ? lvl : 1'b0);
            chk("out_level", pad_out, od ? 1'b0 : lvl);
        end
        wr(`IDX_PIN2_CONTROL, 32'h0, r);
        cyc(3);
        chk("oe_b_off", pad_oe_b_out, 32'h1);
        ext_en <= 1'b1;
        for (k = 0; k < 16; k++) begin
            wr(`IDX_PIN2_CONTROL, 32'h8480 | k, r);
            ext_val <= 1'b1;
            cyc(14);
            chk("in_fn_on", in_function_out, 16'h1 << k);
            ext_val <= 1'b0;
            cyc(14);
            chk("in_fn_off", in_function_out, 32'h0);
        end
        // A short pulse must not pass the de-bounce
        ext_val <= 1'b1;
        cyc(2);
        ext_val <= 1'b0;
        cyc(12);
        chk("glitch", in_function_out, 32'h0);
        wr(`IDX_PIN2_CONTROL, 32'h8081, r);
        cyc(14);
        chk("in_inverted", in_function_out, 32'h2);
        wr(`IDX_IRQ_ENABLE, 32'h1, r);
        for (k = 0; k < 4; k++) begin
            wr(`IDX_PIN2_CONTROL, 32'h8081 | (k[1] << 12) | (k[0] << 10), r);
            cyc(14);
            wr(`IDX_IRQ_CLEAR, 32'h1, r);
            ext_val <= 1'b1;
            cyc(14);
            rd(`IDX_IRQ_STATUS, d, r);
            chk("st_rise", d[0], k[1] | k[0]);
            chk("irq_rise", irq_out, k[1] | k[0]);
            wr(`IDX_IRQ_CLEAR, 32'h1, r);
            ext_val <= 1'b0;
            cyc(14);
            rd(`IDX_IRQ_STATUS, d, r);
            chk("st_fall", d[0], k[1] | !k[0]);
        end
        wr(`IDX_IRQ_CLEAR, 32'h1, r);
        wr(`IDX_IRQ_ENABLE, 32'h0, r);
        ext_val <= 1'b1;
        cyc(14);
        chk("irq_masked", irq_out, 32'h0);
        wr(`IDX_IRQ_ENABLE, 32'h1, r);
        cyc(2);
        chk("irq_unmasked", irq_out, 32'h1);
        wr(`IDX_IRQ_CLEAR, 32'h1, r);
        cyc(2);
        chk("irq_cleared", irq_out, 32'h0);
        rd(`IDX_PIN_LEVEL, d, r);
        chk("level_rd", d, 32'h2 | sw);
        // Mid-run reset from a driven, pulled-up, other-domain setting
        wr(`IDX_PIN2_CONTROL, 32'h5C8F, r);
        wr(`IDX_IRQ_ENABLE, 32'h1, r);
        rst_b_in <= 1'b0;
        cyc(2);
        rst_b_in <= 1'b1;
        @(posedge clk_sys_in);
        rd(`IDX_PIN2_CONTROL, d, r);
        chk("ctl_rerst", d, 32'h0000A400);
        chk("oe_b_rerst", pad_oe_b_out, 32'h1);
        chk("pull_rerst", {pull_up_out, pull_down_out, supply_domain_out}, 32'h2);
        rd(`IDX_IRQ_ENABLE, d, r);
        chk("ena_rerst", d, 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
